// *** core/bwq_defs.svh ***
// Constants of the write response queue: sizes, bit positions and reset values.
`ifndef BWQ_DEFS_SVH
`define BWQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define BWQ_DEPTH 32
`define BWQ_ID_W 4
`define BWQ_USER_W 1
`define BWQ_RESP_W 2
`define BWQ_ECC_EN 1

// ----------------------------------------------------------------------------
// Codeword positions flipped by error injection
// ----------------------------------------------------------------------------
`define BWQ_INJ_POS_A 3
`define BWQ_INJ_POS_B 5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BWQ_RST_LOW 1'h0
`define BWQ_RST_HIGH 1'h1

`endif

// *** core/bwq_pkg.sv ***
// Types shared by the write response queue modules.
package bwq_pkg;

  // --------------------------------------------------------------------------
  // Write response codes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BWQ_OKAY = 2'h0,
    BWQ_EXOKAY = 2'h1,
    BWQ_SLVERR = 2'h2,
    BWQ_DECERR = 2'h3
  } bwq_resp_t;

  // --------------------------------------------------------------------------
  // Decoder result flags
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic sbit;
    logic dbit;
  } bwq_err_t;

endpackage : bwq_pkg

// *** core/bwq_fifo_if.sv ***
// Stream handshake between the queue top and its storage.
`timescale 1ns/1ns
interface bwq_fifo_if #(
  parameter int W = 8
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;

  modport store (
    input wr_valid,
    input wr_data,
    input rd_ready,
    output wr_ready,
    output rd_valid,
    output rd_data
  );

  modport user (
    output wr_valid,
    output wr_data,
    output rd_ready,
    input wr_ready,
    input rd_valid,
    input rd_data
  );
endinterface : bwq_fifo_if

// *** core/bwq_fifo.sv ***
// Synchronous FIFO storage with registered full flag.
`timescale 1ns/1ns
`include "bwq_defs.svh"
module bwq_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `BWQ_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Stream ports.
  bwq_fifo_if.store fb
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
  } bwq_fifo_st_t;

  bwq_fifo_st_t q;
  bwq_fifo_st_t next_q;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // --------------------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------------------
  // Writes are taken only while not full, so nothing stored is overwritten.
  assign push = fb.wr_valid && !q.full;
  assign pop = fb.rd_ready && (q.cnt != '0);
  assign fb.wr_ready = !q.full;
  assign fb.rd_valid = (q.cnt != '0);
  assign fb.rd_data = mem[q.rp];

  // --------------------------------------------------------------------------
  // Pointers and count
  // --------------------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
    end
    if (pop) begin
      next_q.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
    end
    next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_q.full = (next_q.cnt == (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[q.wp] <= fb.wr_data;
    end
  end
endmodule : bwq_fifo

// *** core/bwq_level.sv ***
// Threshold capture and programmable full and empty flags.
`timescale 1ns/1ns
`include "bwq_defs.svh"
module bwq_level #(
  parameter int TW = 5,
  parameter int CW = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Thresholds and occupancy.
  input wire logic [TW-1:0] full_thresh,
  input wire logic [TW-1:0] empty_thresh,
  input wire logic [CW-1:0] count,
  // Flags.
  output logic prog_full,
  output logic prog_empty
);
  typedef struct packed {
    logic loaded;
    logic [TW-1:0] thr_full;
    logic [TW-1:0] thr_empty;
    logic pfull;
    logic pempty;
  } bwq_level_st_t;

  bwq_level_st_t q;
  bwq_level_st_t next_q;

  // --------------------------------------------------------------------------
  // Capture and compare
  // --------------------------------------------------------------------------
  always_comb begin
    next_q = q;
    // Thresholds held through reset are caught on the first enabled edge after it.
    if (!q.loaded) begin
      next_q.loaded = 1'h1;
      next_q.thr_full = full_thresh;
      next_q.thr_empty = empty_thresh;
    end
    next_q.pfull = (count >= CW'(next_q.thr_full));
    next_q.pempty = (count <= CW'(next_q.thr_empty));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.loaded <= `BWQ_RST_LOW;
      q.thr_full <= '1;
      q.thr_empty <= '0;
      q.pfull <= `BWQ_RST_LOW;
      q.pempty <= `BWQ_RST_HIGH;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign prog_full = q.pfull;
  assign prog_empty = q.pempty;
endmodule : bwq_level

// *** core/bwq_top.sv ***
// Write response queue: FIFO between a downstream slave and an upstream master.
//
// Function
// - Response ID passes through unchanged.
// - Two-bit response code passes through unchanged.
// - Master valid high only when response buffered; it rises up to two cycles after the write.
// - Slave-side ready high only when room exists.
// - Master outputs come from FIFO output word.
// - Slave inputs packed into FIFO input word.
// - Full threshold input sets programmable full flag.
// - Empty threshold input sets programmable empty flag.
// - Thresholds caught on first enabled edge after reset; held stable then.
// - Single inject corrupts one stored bit.
// - Double inject corrupts two stored bits.
// - Single error flagged and word corrected.
// - Double error flagged as corrupted data.
// - Overflow never pulses; its term needs slave ready both high and low.
// - Refused write leaves contents and pointers alone.
// - Ready withheld when full; overflow stays low.
// - Programmable full while count at or above threshold.
// - Programmable empty while count at or below threshold.
`timescale 1ns/1ns
`include "bwq_defs.svh"
module bwq_top #(
  parameter int ID_W = `BWQ_ID_W,
  parameter int USER_W = `BWQ_USER_W,
  parameter int DEPTH = `BWQ_DEPTH,
  parameter bit ECC_EN = `BWQ_ECC_EN
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Master-facing response channel.
  output logic [ID_W-1:0] s_axi_bid,
  output logic [`BWQ_RESP_W-1:0] s_axi_bresp,
  output logic [USER_W-1:0] s_axi_buser,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Slave-facing response channel.
  input wire logic [ID_W-1:0] m_axi_bid,
  input wire logic [`BWQ_RESP_W-1:0] m_axi_bresp,
  input wire logic [USER_W-1:0] m_axi_buser,
  input wire logic m_axi_bvalid,
  output logic m_axi_bready,
  // Thresholds and level flags.
  input wire logic [$clog2(DEPTH)-1:0] prog_full_thresh,
  input wire logic [$clog2(DEPTH)-1:0] prog_empty_thresh,
  output logic prog_full,
  output logic prog_empty,
  // Error injection and reporting.
  input wire logic inject_sbit_err,
  input wire logic inject_dbit_err,
  output logic sbit_err,
  output logic dbit_err,
  output logic overflow
);

  // --------------------------------------------------------------------------
  // Sizes of the word and its codeword
  // --------------------------------------------------------------------------
  function automatic int calc_parity(input int k);
    int p;
    p = 0;
    for (int x = 1; x < 16; x++) begin
      if ((p == 0) && ((1 << x) >= (k + x + 1))) begin
        p = x;
      end
    end
    return p;
  endfunction : calc_parity

  localparam int K = ID_W + `BWQ_RESP_W + USER_W;
  localparam int P = calc_parity(K);
  localparam int N = K + P;
  localparam int TW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1) + 1;

  typedef struct packed {
    logic [K-1:0] data;
    bwq_pkg::bwq_err_t err;
  } bwq_dec_t;

  // --------------------------------------------------------------------------
  // Error correcting encoder
  // --------------------------------------------------------------------------
  // Position 0 holds overall parity, powers of two hold Hamming parity.
  function automatic logic [N:0] ecc_enc(
    input logic [K-1:0] d,
    input logic inj_s,
    input logic inj_d
  );
    logic [N:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i <= N; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    end
    for (int j = 0; j < P; j++) begin
      for (int i = 1; i <= N; i++) begin
        if (i[j] && (i != (1 << j))) begin
          c[1 << j] = c[1 << j] ^ c[i];
        end
      end
    end
    c[0] = ^c[N:1];
    if (ECC_EN) begin
      c[`BWQ_INJ_POS_A] = c[`BWQ_INJ_POS_A] ^ (inj_s | inj_d);
      c[`BWQ_INJ_POS_B] = c[`BWQ_INJ_POS_B] ^ inj_d;
    end
    return c;
  endfunction : ecc_enc

  // --------------------------------------------------------------------------
  // Error correcting decoder
  // --------------------------------------------------------------------------
  function automatic bwq_dec_t ecc_dec(input logic [N:0] c);
    bwq_dec_t r;
    logic [N:0] f;
    int s;
    int k;
    logic par;
    r = '0;
    f = c;
    s = 0;
    k = 0;
    par = ^c;
    for (int i = 1; i <= N; i++) begin
      if (c[i]) begin
        s = s ^ i;
      end
    end
    // Odd parity means one flipped bit, which the syndrome locates.
    if (par && (s != 0) && (s <= N)) begin
      f[s] = ~f[s];
    end
    for (int i = 1; i <= N; i++) begin
      if ((i & (i - 1)) != 0) begin
        r.data[k] = f[i];
        k++;
      end
    end
    if (ECC_EN) begin
      r.err.sbit = par;
      r.err.dbit = !par && (s != 0);
    end
    return r;
  endfunction : ecc_dec

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic vld;
    logic [ID_W-1:0] id;
    bwq_pkg::bwq_resp_t resp;
    logic [USER_W-1:0] user;
    logic sbit;
    logic dbit;
    logic ovf;
  } bwq_top_st_t;

  bwq_top_st_t q;
  bwq_top_st_t next_q;
  bwq_dec_t dec;
  logic push;
  logic take;
  logic drain;

  bwq_fifo_if #(.W(N + 1)) fb ();

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  bwq_fifo #(
    .W(N + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .fb(fb)
  );

  // Slave-side word goes in with its code bits; ready is the registered room flag.
  assign fb.wr_valid = m_axi_bvalid;
  assign fb.wr_data = ecc_enc({m_axi_bid, m_axi_bresp, m_axi_buser}, inject_sbit_err,
                              inject_dbit_err);
  assign m_axi_bready = fb.wr_ready;
  assign push = m_axi_bvalid && fb.wr_ready;

  // --------------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------------
  // The output register refills whenever it is empty or being emptied.
  assign drain = q.vld && s_axi_bready;
  assign take = fb.rd_valid && (!q.vld || s_axi_bready);
  assign fb.rd_ready = take;
  assign dec = ecc_dec(fb.rd_data);

  always_comb begin
    next_q = q;
    next_q.sbit = 1'h0;
    next_q.dbit = 1'h0;
    if (take) begin
      next_q.vld = 1'h1;
      // The code field is cast on its own, since an enum cannot be filled by concatenation.
      next_q.id = dec.data[K-1 -: ID_W];
      next_q.resp = bwq_pkg::bwq_resp_t'(dec.data[USER_W +: `BWQ_RESP_W]);
      next_q.user = dec.data[USER_W-1:0];
      next_q.sbit = dec.err.sbit;
      next_q.dbit = dec.err.dbit;
    end else if (drain) begin
      next_q.vld = 1'h0;
    end
    next_q.cnt = q.cnt + CW'(push) - CW'(drain);
    // A refused write needs valid while full, yet ready is low then, so this stays low.
    next_q.ovf = m_axi_bvalid && fb.wr_ready && !fb.wr_ready;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // --------------------------------------------------------------------------
  // Level flags
  // --------------------------------------------------------------------------
  bwq_level #(
    .TW(TW),
    .CW(CW)
  ) u_level (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .full_thresh(prog_full_thresh),
    .empty_thresh(prog_empty_thresh),
    .count(next_q.cnt),
    .prog_full(prog_full),
    .prog_empty(prog_empty)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_bvalid = q.vld;
  assign s_axi_bid = q.id;
  assign s_axi_bresp = q.resp;
  assign s_axi_buser = q.user;
  assign sbit_err = q.sbit;
  assign dbit_err = q.dbit;
  assign overflow = q.ovf;

endmodule : bwq_top

// *** dv/bwq_properties.sv ***
// Concurrent checks on the ports of the write response queue.
`timescale 1ns/1ns
`include "bwq_defs.svh"
module bwq_properties #(
  parameter int ID_W = 4,
  parameter int USER_W = 1,
  parameter int DEPTH = 32,
  parameter bit ECC_EN = 1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Master-facing channel.
  input wire logic [ID_W-1:0] s_axi_bid,
  input wire logic [`BWQ_RESP_W-1:0] s_axi_bresp,
  input wire logic [USER_W-1:0] s_axi_buser,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Slave-facing channel.
  input wire logic [ID_W-1:0] m_axi_bid,
  input wire logic [`BWQ_RESP_W-1:0] m_axi_bresp,
  input wire logic [USER_W-1:0] m_axi_buser,
  input wire logic m_axi_bvalid,
  input wire logic m_axi_bready,
  // Levels and errors.
  input wire logic [$clog2(DEPTH)-1:0] prog_full_thresh,
  input wire logic [$clog2(DEPTH)-1:0] prog_empty_thresh,
  input wire logic prog_full,
  input wire logic prog_empty,
  input wire logic inject_sbit_err,
  input wire logic inject_dbit_err,
  input wire logic sbit_err,
  input wire logic dbit_err,
  input wire logic overflow
);
  // ----------
  // Occupancy
  // ----------
  logic [6:0] occ;
  logic armed;
  logic inj_seen;
  logic [$clog2(DEPTH)-1:0] fthr;
  logic [$clog2(DEPTH)-1:0] ethr;
  logic wr;
  logic rd;
  assign wr = ce && m_axi_bvalid && m_axi_bready;
  assign rd = ce && s_axi_bvalid && s_axi_bready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      occ <= 7'h00;
      armed <= 1'h0;
      inj_seen <= 1'h0;
      fthr <= '0;
      ethr <= '0;
    end else if (ce) begin
      occ <= occ + 7'(wr) - 7'(rd);
      armed <= 1'h1;
      if (!armed) begin
        fthr <= prog_full_thresh;
        ethr <= prog_empty_thresh;
      end
      if (wr && (inject_sbit_err || inject_dbit_err)) begin
        inj_seen <= 1'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // Properties
  // ----------
  property p_no_overflow;
    !overflow;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("overflow raised");
  property p_ready_room;
    m_axi_bready == ((occ - 7'(s_axi_bvalid)) != 7'(DEPTH));
  endproperty
  a_ready_room: assert property (p_ready_room)
    else $error("slave ready does not match room");
  property p_empty_quiet;
    occ == 7'h00 |-> !s_axi_bvalid;
  endproperty
  a_empty_quiet: assert property (p_empty_quiet)
    else $error("valid with nothing buffered");
  property p_valid_soon;
    occ != 7'h00 |-> ##[0:2] s_axi_bvalid;
  endproperty
  a_valid_soon: assert property (p_valid_soon)
    else $error("buffered response not presented");
  property p_hold;
    s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable({s_axi_bid, s_axi_bresp, s_axi_buser});
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled response changed");
  property p_prog_full;
    armed |-> prog_full == (occ >= 7'(fthr));
  endproperty
  a_prog_full: assert property (p_prog_full)
    else $error("full flag wrong");
  property p_prog_empty;
    armed |-> prog_empty == (occ <= 7'(ethr));
  endproperty
  a_prog_empty: assert property (p_prog_empty)
    else $error("empty flag wrong");
  property p_err_with_word;
    sbit_err || dbit_err |-> s_axi_bvalid;
  endproperty
  a_err_with_word: assert property (p_err_with_word)
    else $error("error flag without a word");
  property p_no_inject_no_err;
    !inj_seen |-> !sbit_err && !dbit_err;
  endproperty
  a_no_inject_no_err: assert property (p_no_inject_no_err)
    else $error("error flag without injection");
endmodule : bwq_properties

bind bwq_top bwq_properties #(.ID_W(ID_W), .USER_W(USER_W), .DEPTH(DEPTH),
  .ECC_EN(ECC_EN)) u_props (.*);

// *** dv/bwq_slave_model.sv ***
// Downstream slave that feeds write responses into the queue.
`timescale 1ns/1ns
module bwq_slave_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Response channel toward the queue.
  output logic [3:0] bid,
  output logic [1:0] bresp,
  output logic [0:0] buser,
  output logic bvalid,
  input wire logic bready,
  // Error injection.
  output logic inj_s,
  output logic inj_d
);
  logic [8:0] q[$];
  bit slow;
  bit rest;
  task automatic push(input logic [8:0] w);
    q.push_back(w);
  endtask : push
  initial {bvalid, bid, bresp, buser, inj_s, inj_d} = 10'h000;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'h0;
      rest <= 1'h0;
    end else if (!bvalid || bready) begin
      if (q.size() == 0 || (slow && !rest)) begin
        bvalid <= 1'h0;
        {bid, bresp, buser, inj_s, inj_d} <= ~{bid, bresp, buser, inj_s, inj_d};
        rest <= 1'h1;
      end else begin
        {bid, bresp, buser, inj_s, inj_d} <= q.pop_front();
        bvalid <= 1'h1;
        rest <= 1'h0;
      end
    end
  end
endmodule : bwq_slave_model

// *** dv/tb_top.sv ***
// Self-checking bench for the write response queue.
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] s_axi_bid;
  logic [1:0] s_axi_bresp;
  logic [0:0] s_axi_buser;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [3:0] m_axi_bid;
  logic [1:0] m_axi_bresp;
  logic [0:0] m_axi_buser;
  logic m_axi_bvalid;
  logic m_axi_bready;
  logic [4:0] fthr_in = 5'h14;
  logic [4:0] ethr_in = 5'h03;
  logic prog_full;
  logic prog_empty;
  logic inj_s;
  logic inj_d;
  logic sbit_err;
  logic dbit_err;
  logic overflow;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int occ = 0;

  always #5 clk = ~clk;

  bwq_top u_dut (.clk(clk), .rst_n(rst_n), .ce(1'h1),
    .s_axi_bid(s_axi_bid), .s_axi_bresp(s_axi_bresp), .s_axi_buser(s_axi_buser),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .m_axi_bid(m_axi_bid), .m_axi_bresp(m_axi_bresp), .m_axi_buser(m_axi_buser),
    .m_axi_bvalid(m_axi_bvalid), .m_axi_bready(m_axi_bready),
    .prog_full_thresh(fthr_in), .prog_empty_thresh(ethr_in),
    .prog_full(prog_full), .prog_empty(prog_empty),
    .inject_sbit_err(inj_s), .inject_dbit_err(inj_d),
    .sbit_err(sbit_err), .dbit_err(dbit_err), .overflow(overflow));

  bwq_slave_model u_slv (.clk(clk), .rst_n(rst_n), .bid(m_axi_bid),
    .bresp(m_axi_bresp), .buser(m_axi_buser), .bvalid(m_axi_bvalid),
    .bready(m_axi_bready), .inj_s(inj_s), .inj_d(inj_d));

  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic take(input logic [6:0] w, input logic [1:0] err, input bit cmp_data);
    int n;
    n = 0;
    s_axi_bready <= 1'h1;
    @(posedge clk);
    while (s_axi_bvalid !== 1'h1 && n < 200) begin
      n++;
      @(posedge clk);
    end
    check(32'(n < 200), 32'h1);
    if (cmp_data) check(32'({s_axi_bid, s_axi_bresp, s_axi_buser}), 32'(w));
    check(32'({sbit_err, dbit_err}), 32'(err));
  endtask : take

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ----------
  // Monitors
  // ----------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  always @(posedge clk) begin
    if (rst_n !== 1'h1) begin
      occ = 0;
    end else begin
      check(32'(prog_full), 32'(occ >= fthr_in));
      check(32'(prog_empty), 32'(occ <= ethr_in));
      check(32'(overflow), 32'h0);
      occ = occ + int'(m_axi_bvalid & m_axi_bready) - int'(s_axi_bvalid & s_axi_bready);
    end
  end

  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    check(32'({s_axi_bvalid, m_axi_bready, prog_full, prog_empty}), 32'h5);
    for (int i = 0; i < 8; i++) u_slv.push({4'(i * 3), 2'(i), 1'(i), 2'h0});
    for (int i = 0; i < 8; i++) take({4'(i * 3), 2'(i), 1'(i)}, 2'h0, 1'h1);
    u_slv.slow = 1'h1;
    u_slv.push({4'hA, 2'h2, 1'h1, 2'h2});
    take({4'hA, 2'h2, 1'h1}, 2'h2, 1'h1);
    u_slv.push({4'h5, 2'h1, 1'h0, 2'h1});
    take({4'h5, 2'h1, 1'h0}, 2'h1, 1'h0);
    u_slv.push({4'h6, 2'h3, 1'h1, 2'h0});
    take({4'h6, 2'h3, 1'h1}, 2'h0, 1'h1);
    u_slv.slow = 1'h0;
    s_axi_bready <= 1'h0;
    for (int i = 0; i < 34; i++) u_slv.push({4'(i), 2'(i), 1'(i), 2'h0});
    repeat (45) @(posedge clk);
    check(32'({m_axi_bready, s_axi_bvalid, m_axi_bvalid}), 32'h3);
    for (int i = 0; i < 34; i++) take({4'(i), 2'(i), 1'(i)}, 2'h0, 1'h1);
    rst_n <= 1'h0;
    fthr_in <= 5'h05;
    ethr_in <= 5'h01;
    s_axi_bready <= 1'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 8; i++) u_slv.push({4'(15 - i), 2'(i), 1'(i), 2'h0});
    repeat (20) @(posedge clk);
    for (int i = 0; i < 8; i++) take({4'(15 - i), 2'(i), 1'(i)}, 2'h0, 1'h1);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_top
